// File: pin_cfg.svh
// address map, reset values and bus codes of the multifunction pin block
`ifndef PIN_CFG_SVH
`define PIN_CFG_SVH
// ==========================================================
// register byte offsets (low address byte)
`define GP_CFG_BASE    8'h00
`define GP_CFG_TOP     8'h3c
`define GP_OUT_VALUE   8'h40
`define GP_IN_LEVEL    8'h44
`define GP_STICKY      8'h48
`define GP_ALERT_EN    8'h4c
`define GP_VDD_LEVEL   8'h50
`define GP_LIVE        8'h54
// ==========================================================
// field layout and reset values
`define GP_HOLD_LSB    8
`define GP_CFG_RESET   32'h0000_0100
`define GP_CFG_WMASK   32'hffff_0fff
`define GP_WORD_LSB    2
`define GP_IDX_MSB     5
`define GP_ADDR_MSB    7
// ==========================================================
// bus codes
`define GP_HTRANS_IDLE 2'b00
`define GP_HSIZE_WORD  3'b010
`define GP_HRESP_OKAY  1'b0
`endif

// File: pin_pkg.sv
// types shared by the multifunction pin block
package pin_pkg;
  // ==========================================================
  // pin functions; input is the reset default
  typedef enum logic [3:0] {
    FN_INPUT, FN_OUTPUT, FN_LOS, FN_LOCK, FN_HOLD, FN_ALERT,
    FN_OUT_DIS, FN_SE_CLK, FN_MAN_SEL, FN_INC, FN_DEC, FN_DISQ
  } func_type;
  // ==========================================================
  // one configuration word per pin
  typedef struct packed {
    logic [15:0] out_mask;
    logic [3:0]  spare;
    logic [2:0]  src;
    logic        pull_up;
    logic        push_pull;
    logic        enable;
    logic        sticky;
    logic        invert;
    func_type    func;
  } pin_cfg_type;
endpackage

// File: pin_sync.sv
// two-stage pin synchroniser with single-cycle rising-edge pulse
`timescale 1ns/1ns
module pin_sync #(
  parameter int NPIN = 16
) (
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  input  wire logic [NPIN-1:0] i_raw,
  output logic      [NPIN-1:0] o_level,
  output logic      [NPIN-1:0] o_rise
);
  logic [NPIN-1:0] meta;
  logic [NPIN-1:0] last;

  // ==========================================================
  // synchroniser: meta is read only by the second stage
  // runs through reset so the level has settled when reset ends
  always_ff @(posedge i_clk) begin
    meta    <= i_raw;
    o_level <= meta;
  end

  // edge detect on the settled level, one pulse per rising transition
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      last   <= o_level;   // tracks the pin in reset: no false edge on release
      o_rise <= '0;
    end else begin
      last   <= o_level;
      o_rise <= o_level & ~last;
    end
  end

  AST_RISE_SINGLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rise[0] |=> !o_rise[0]) else $error("rise pulse longer than one cycle");
endmodule // pin_sync

// File: gpio_mux.sv
// multifunction pin block: sixteen configurable pins behind an AHB-Lite slave
// Notes on behaviour
// - sixteen pins, numbered zero to fifteen, each with its own configuration word.
// - pin functions act only once the device reset sequence has finished.
// - input function shows the synchronised pin level; it is the default.
// - output function drives the level held in the output value register.
// - pins with identical loss-of-signal, lock, holdover or alert configuration show identical outputs.
// - loss-of-signal drives the live monitor alarm, high active, invertible.
// - live loss-of-lock is high while the selected loop is unlocked.
// - sticky loss-of-lock flags any lock change until software clears it.
// - live holdover is high while the selected loop is in holdover.
// - sticky holdover flags any holdover change until software clears it.
// - alert is the OR of enabled sticky bits only, never live ones.
// - alert is high active, invertible, held until every contributor is cleared.
// - output disable pin high turns the selected clock outputs off.
// - each disable pin controls its own selectable subset of clock outputs.
// - single-ended clock pin is routed unless its stage is already full.
// - manual select pin high picks the higher-priority reference, low the lower.
// - increment pin rising edge steps the chosen oscillator up.
// - decrement pin rising edge steps the chosen oscillator down.
// - disqualification pin high disqualifies the preset reference for its loop.
// - enabled output pins drive open-drain or push-pull as configured.
// - each pin selects pull-up or pull-down; pull-up after reset.
// - sticky bits set on any live change and hold until cleared.
`timescale 1ns/1ns
`include "pin_cfg.svh"
module gpio_mux #(
  parameter int NPIN = 16,
  parameter int NOUT = 16,
  parameter int NCH  = 8
) (
  input  wire logic            I_SYS_CLK,
  input  wire logic            I_NRST,
  input  wire logic            I_RESET_DONE,
  input  wire logic            I_HSEL,
  input  wire logic [31:0]     I_HADDR,
  input  wire logic [1:0]      I_HTRANS,
  input  wire logic            I_HWRITE,
  input  wire logic [2:0]      I_HSIZE,
  input  wire logic [31:0]     I_HWDATA,
  input  wire logic            I_HREADY,
  output logic      [31:0]     O_HRDATA,
  output logic                 O_HREADYOUT,
  output logic                 O_HRESP,
  input  wire logic [NPIN-1:0] I_PIN,
  output logic      [NPIN-1:0] O_PIN,
  output logic      [NPIN-1:0] O_PIN_OE_N,
  output logic      [NPIN-1:0] O_PULL_UP,
  output logic      [1:0]      O_PIN_VDD_LEVEL,
  input  wire logic [NCH-1:0]  I_REF_LOS,
  input  wire logic [NCH-1:0]  I_LOOP_LOCKED,
  input  wire logic [NCH-1:0]  I_LOOP_HOLDOVER,
  input  wire logic [NPIN-1:0] I_STAGE_SE_FULL,
  output logic      [NPIN-1:0] O_SE_CLK,
  output logic      [NOUT-1:0] O_CLKOUT_DISABLE,
  output logic      [NCH-1:0]  O_MAN_SEL_ACTIVE,
  output logic      [NCH-1:0]  O_MAN_SEL_HIGH,
  output logic      [NCH-1:0]  O_DCO_INC,
  output logic      [NCH-1:0]  O_DCO_DEC,
  output logic      [NCH-1:0]  O_DISQUALIFY
);
  // ==========================================================
  // elaboration checks
  if (NPIN != 16 || NOUT < 1 || NOUT > 16 || NCH < 1 || NCH > 8) begin : g_bad_param
    $error("gpio_mux: unsupported NPIN, NOUT or NCH");
  end

  pin_pkg::pin_cfg_type cfg [NPIN];
  logic [NPIN-1:0]       out_value;
  logic [NCH-1:0]        alert_lock_en;
  logic [NCH-1:0]        alert_hold_en;
  logic [NCH-1:0]        lock_sticky;
  logic [NCH-1:0]        hold_sticky;
  logic [NCH-1:0]        lock_last;
  logic [NCH-1:0]        hold_last;
  logic [1:0]            vdd_level;
  logic [NPIN-1:0]       pin_level;
  logic [NPIN-1:0]       pin_rise;
  logic [NPIN-1:0]       se_en;
  logic                  wr_pend;
  logic                  rd_pend;
  logic                  rd_done;
  logic [`GP_ADDR_MSB:0] addr_q;
  logic [31:0]           rd_word;
  logic [NCH-1:0]        lock_clr;
  logic [NCH-1:0]        hold_clr;
  logic                  alert_any;
  logic [NPIN-1:0]       next_pin;
  logic [NPIN-1:0]       next_oe_n;
  logic [NPIN-1:0]       next_se_en;
  logic [NOUT-1:0]       next_clk_dis;
  logic [NCH-1:0]        next_man_act;
  logic [NCH-1:0]        next_man_high;
  logic [NCH-1:0]        next_inc;
  logic [NCH-1:0]        next_dec;
  logic [NCH-1:0]        next_disq;

  // ==========================================================
  // helpers
  // out-of-range channel selections read as inactive
  function automatic logic pick(input logic [NCH-1:0] vec, input logic [2:0] sel);
    pick = (int'(sel) < NCH) ? vec[sel] : 1'b0;
  endfunction

  function automatic logic [NCH-1:0] chan_hot(input logic [2:0] sel, input logic on);
    chan_hot = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      if (on && sel == 3'(ch))
        chan_hot[ch] = 1'b1;
    end
  endfunction

  // ==========================================================
  // pin input synchroniser and edge detector
  pin_sync #(.NPIN(NPIN)) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_raw   (I_PIN),
    .o_level (pin_level),
    .o_rise  (pin_rise)
  );

  // ==========================================================
  // bus slave: address phase capture
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= '0;
    end else if (I_HREADY) begin
      wr_pend <= I_HSEL && I_HTRANS[1] && I_HWRITE;
      rd_pend <= I_HSEL && I_HTRANS[1] && !I_HWRITE;
      addr_q  <= I_HADDR[`GP_ADDR_MSB:0];
    end
  end

  // reads take one wait state so that a write just before is seen
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      rd_done  <= 1'b0;
      O_HRDATA <= '0;
    end else if (rd_pend && !rd_done) begin
      rd_done  <= 1'b1;
      O_HRDATA <= rd_word;
    end else if (I_HREADY) begin
      rd_done  <= 1'b0;
    end
  end

  assign O_HREADYOUT = !(rd_pend && !rd_done);
  assign O_HRESP     = `GP_HRESP_OKAY;

  // read decode; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (addr_q <= `GP_CFG_TOP) begin
      rd_word = cfg[addr_q[`GP_IDX_MSB:`GP_WORD_LSB]];
    end else if (addr_q == `GP_OUT_VALUE) begin
      rd_word[NPIN-1:0] = out_value;
    end else if (addr_q == `GP_IN_LEVEL) begin
      rd_word[NPIN-1:0] = pin_level;
    end else if (addr_q == `GP_STICKY) begin
      rd_word[NCH-1:0] = lock_sticky;
      rd_word[`GP_HOLD_LSB +: NCH] = hold_sticky;
    end else if (addr_q == `GP_ALERT_EN) begin
      rd_word[NCH-1:0] = alert_lock_en;
      rd_word[`GP_HOLD_LSB +: NCH] = alert_hold_en;
    end else if (addr_q == `GP_VDD_LEVEL) begin
      rd_word[1:0] = vdd_level;
    end else if (addr_q == `GP_LIVE) begin
      rd_word[NCH-1:0] = I_LOOP_LOCKED;
      rd_word[`GP_HOLD_LSB +: NCH] = I_LOOP_HOLDOVER;
    end
  end

  // ==========================================================
  // configuration registers, written in the data phase
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      for (int p = 0; p < NPIN; p++)
        cfg[p] <= `GP_CFG_RESET;
      out_value     <= '0;
      alert_lock_en <= '0;
      alert_hold_en <= '0;
      vdd_level     <= '0;
    end else if (wr_pend) begin
      if (addr_q <= `GP_CFG_TOP) begin
        cfg[addr_q[`GP_IDX_MSB:`GP_WORD_LSB]] <= I_HWDATA & `GP_CFG_WMASK;
      end else if (addr_q == `GP_OUT_VALUE) begin
        out_value <= I_HWDATA[NPIN-1:0];
      end else if (addr_q == `GP_ALERT_EN) begin
        alert_lock_en <= I_HWDATA[NCH-1:0];
        alert_hold_en <= I_HWDATA[`GP_HOLD_LSB +: NCH];
      end else if (addr_q == `GP_VDD_LEVEL) begin
        vdd_level <= I_HWDATA[1:0];
      end
    end
  end

  // ==========================================================
  // sticky alarms: write one to clear, a new change wins over the clear
  assign lock_clr = (wr_pend && addr_q == `GP_STICKY) ? I_HWDATA[NCH-1:0] : '0;
  assign hold_clr = (wr_pend && addr_q == `GP_STICKY) ? I_HWDATA[`GP_HOLD_LSB +: NCH] : '0;

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST) begin
      lock_last   <= I_LOOP_LOCKED;     // follow the live state: no change seen on release
      hold_last   <= I_LOOP_HOLDOVER;
      lock_sticky <= '0;
      hold_sticky <= '0;
    end else begin
      lock_last   <= I_LOOP_LOCKED;
      hold_last   <= I_LOOP_HOLDOVER;
      lock_sticky <= (lock_sticky & ~lock_clr) | (lock_last ^ I_LOOP_LOCKED);
      hold_sticky <= (hold_sticky & ~hold_clr) | (hold_last ^ I_LOOP_HOLDOVER);
    end
  end

  // only sticky bits feed the alert, so the cause survives until read
  assign alert_any = |(lock_sticky & alert_lock_en) | |(hold_sticky & alert_hold_en);

  // ==========================================================
  // per-pin function selection
  always_comb begin
    logic val;
    logic drv;
    next_pin      = '0;
    next_oe_n     = '1;
    next_se_en    = '0;
    next_clk_dis  = '0;
    next_man_act  = '0;
    next_man_high = '0;
    next_inc      = '0;
    next_dec      = '0;
    next_disq     = '0;
    val           = 1'b0;
    drv           = 1'b0;
    for (int p = 0; p < NPIN; p++) begin
      val = 1'b0;
      drv = 1'b0;
      case (cfg[p].func)
        pin_pkg::FN_OUTPUT: begin
          val = out_value[p];
          drv = 1'b1;
        end
        pin_pkg::FN_LOS: begin
          val = pick(I_REF_LOS, cfg[p].src) ^ cfg[p].invert;
          drv = 1'b1;
        end
        pin_pkg::FN_LOCK: begin
          val = (cfg[p].sticky ? pick(lock_sticky, cfg[p].src)
                               : !pick(I_LOOP_LOCKED, cfg[p].src))
                ^ cfg[p].invert;
          drv = 1'b1;
        end
        pin_pkg::FN_HOLD: begin
          val = (cfg[p].sticky ? pick(hold_sticky, cfg[p].src)
                               : pick(I_LOOP_HOLDOVER, cfg[p].src))
                ^ cfg[p].invert;
          drv = 1'b1;
        end
        pin_pkg::FN_ALERT: begin
          val = alert_any ^ cfg[p].invert;
          drv = 1'b1;
        end
        pin_pkg::FN_OUT_DIS: begin
          if (pin_level[p])
            next_clk_dis = next_clk_dis | cfg[p].out_mask[NOUT-1:0];
        end
        pin_pkg::FN_SE_CLK: begin
          next_se_en[p] = !I_STAGE_SE_FULL[p];
        end
        pin_pkg::FN_MAN_SEL: begin
          next_man_act  = next_man_act | chan_hot(cfg[p].src, 1'b1);
          next_man_high = next_man_high | chan_hot(cfg[p].src, pin_level[p]);
        end
        pin_pkg::FN_INC: begin
          next_inc = next_inc | chan_hot(cfg[p].src, pin_rise[p]);
        end
        pin_pkg::FN_DEC: begin
          next_dec = next_dec | chan_hot(cfg[p].src, pin_rise[p]);
        end
        pin_pkg::FN_DISQ: begin
          next_disq = next_disq | chan_hot(cfg[p].src, pin_level[p]);
        end
        default: begin
          drv = 1'b0;   // plain input: pin stays released
        end
      endcase
      // open drain only ever pulls low; the pull-up gives the high level
      if (drv && cfg[p].enable) begin
        next_pin[p]  = cfg[p].push_pull ? val : 1'b0;
        next_oe_n[p] = cfg[p].push_pull ? 1'b0 : val;
      end
    end
  end

  // ==========================================================
  // registered outputs; all functions held off during reset sequence
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_NRST || !I_RESET_DONE) begin
      O_PIN            <= '0;
      O_PIN_OE_N       <= '1;
      se_en            <= '0;
      O_CLKOUT_DISABLE <= '0;
      O_MAN_SEL_ACTIVE <= '0;
      O_MAN_SEL_HIGH   <= '0;
      O_DCO_INC        <= '0;
      O_DCO_DEC        <= '0;
      O_DISQUALIFY     <= '0;
    end else begin
      O_PIN            <= next_pin;
      O_PIN_OE_N       <= next_oe_n;
      se_en            <= next_se_en;
      O_CLKOUT_DISABLE <= next_clk_dis;
      O_MAN_SEL_ACTIVE <= next_man_act;
      O_MAN_SEL_HIGH   <= next_man_high;
      O_DCO_INC        <= next_inc;
      O_DCO_DEC        <= next_dec;
      O_DISQUALIFY     <= next_disq;
    end
  end

  // clock path is gated, not sampled: a 100 MHz sample would destroy it
  assign O_SE_CLK = I_PIN & se_en;

  always_comb begin
    for (int p = 0; p < NPIN; p++)
      O_PULL_UP[p] = cfg[p].pull_up;
  end

  assign O_PIN_VDD_LEVEL = vdd_level;

  // ==========================================================
  // assertions
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);

  AST_HELD_IN_RESET: assert property (!I_RESET_DONE |=> O_PIN_OE_N == '1 && O_DCO_INC == '0)
    else $error("pins active during reset sequence");
  AST_OUTPUT_LEVEL: assert property (cfg[15].func == pin_pkg::FN_OUTPUT && cfg[15].enable &&
    cfg[15].push_pull && I_RESET_DONE |=> !O_PIN_OE_N[15] && O_PIN[15] == $past(out_value[15]))
    else $error("output pin does not follow output value");
  AST_SAME_CONFIG: assert property (cfg[0] == cfg[1] && I_RESET_DONE &&
    cfg[0].func inside {pin_pkg::FN_LOS, pin_pkg::FN_LOCK, pin_pkg::FN_HOLD, pin_pkg::FN_ALERT}
    |=> O_PIN[0] == O_PIN[1] && O_PIN_OE_N[0] == O_PIN_OE_N[1])
    else $error("equally configured pins differ");
  AST_STICKY_SET: assert property ($changed(I_LOOP_LOCKED[0]) |=> lock_sticky[0])
    else $error("lock change not latched");
  AST_STICKY_HOLD: assert property (hold_sticky[1] && !hold_clr[1] |=> hold_sticky[1])
    else $error("sticky holdover lost without clear");
  AST_OPEN_DRAIN: assert property (!O_PIN_OE_N[15] && !$past(cfg[15].push_pull) |-> !O_PIN[15])
    else $error("open drain pin driven high");
  AST_ALERT_ON: assert property (cfg[13].func == pin_pkg::FN_ALERT && cfg[13].enable &&
    cfg[13].push_pull && !cfg[13].invert && alert_any && I_RESET_DONE |=> O_PIN[13])
    else $error("alert not raised by enabled sticky bit");
  AST_LIVE_LOCK: assert property (cfg[10].func == pin_pkg::FN_LOCK && !cfg[10].sticky &&
    !cfg[10].invert && cfg[10].push_pull && cfg[10].enable && cfg[10].src == 3'h0 && I_RESET_DONE
    |=> O_PIN[10] == !$past(I_LOOP_LOCKED[0]))
    else $error("live loss of lock wrong");
  AST_INC_EDGE: assert property (pin_rise[3] && cfg[3].func == pin_pkg::FN_INC &&
    cfg[3].src == 3'h3 && I_RESET_DONE |=> O_DCO_INC[3])
    else $error("increment edge gave no pulse");
  AST_READ_WAIT: assert property (!O_HREADYOUT |=> O_HREADYOUT)
    else $error("read wait longer than one cycle");

  COV_ALERT: cover property (alert_any ##1 !alert_any);
  COV_INC: cover property (O_DCO_INC[3]);
  COV_CLK_DIS: cover property (O_CLKOUT_DISABLE != '0);
  COV_STICKY_CLR: cover property (lock_sticky[0] ##1 !lock_sticky[0]);
endmodule // gpio_mux

// File: board_model.sv
// board side of the pins: external drivers, pulls and wire level
`timescale 1ns/1ns
module board_model (
  input  wire logic [15:0] i_pin,
  input  wire logic [15:0] i_oe_n,
  input  wire logic [15:0] i_pull_up,
  input  wire logic [15:0] i_ext_val,
  input  wire logic [15:0] i_ext_en,
  output logic      [15:0] o_wire
);
  // ==========================================================
  // wire resolution
  // device wins while it drives; a pin nobody drives settles to its pull,
  // so a stale level never passes for a driven one
  assign o_wire = (~i_oe_n & i_pin) | (i_oe_n & i_ext_en & i_ext_val) | (i_oe_n & ~i_ext_en & i_pull_up);
endmodule // board_model

// File: test_multifunction_pin_control.sv
// self-checking bench for the multifunction pin block
`timescale 1ns/1ns
`include "pin_cfg.svh"
module test_multifunction_pin_control;
  // ==========================================================
  // signals
  localparam logic [4:0] PP = 5'h1c; // pull-up, push-pull, enabled
  logic        clk, nrst, rdone, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans, vdd;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [15:0] pin_w, o_pin, oe_n, pull, ext_v, ext_e, full, se_clk, clk_dis;
  logic [7:0]  los, lkd, hold, ms_act, ms_hi, inc, dec, disq;
  int          error_cnt, tests_run;
  // design and board; hreadyout loops back as the bus hready
  gpio_mux dut_u (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_RESET_DONE(rdone), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(`GP_HSIZE_WORD), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_PIN(pin_w),
    .O_PIN(o_pin), .O_PIN_OE_N(oe_n), .O_PULL_UP(pull), .O_PIN_VDD_LEVEL(vdd), .I_REF_LOS(los),
    .I_LOOP_LOCKED(lkd), .I_LOOP_HOLDOVER(hold), .I_STAGE_SE_FULL(full), .O_SE_CLK(se_clk),
    .O_CLKOUT_DISABLE(clk_dis), .O_MAN_SEL_ACTIVE(ms_act), .O_MAN_SEL_HIGH(ms_hi), .O_DCO_INC(inc),
    .O_DCO_DEC(dec), .O_DISQUALIFY(disq));
  board_model board_u (.i_pin(o_pin), .i_oe_n(oe_n), .i_pull_up(pull), .i_ext_val(ext_v),
    .i_ext_en(ext_e), .o_wire(pin_w));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // looked at mid-cycle so the sampling edge never races the design
  task wait_rdy;
    do @(negedge clk); while (hready !== 1'b1);
    @(posedge clk);
  endtask
  // one single word transfer; read data lands in rdata
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= `GP_HTRANS_IDLE;
    hwdata <= d;
    wait_rdy;
    rdata = hrdata;
    chk(hresp, `GP_HRESP_OKAY);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  function automatic logic [31:0] mk(logic [3:0] f, logic [4:0] fl, logic [2:0] s, logic [15:0] m);
    return {m, 4'h0, s, fl, f};
  endfunction
  task cfg(input int n, input logic [31:0] v);
    ahb(1'b1, 8'(n * 4), v);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task test_reset;
    rd(`GP_CFG_BASE, `GP_CFG_RESET);
    rd(`GP_CFG_TOP, `GP_CFG_RESET);
    rd(8'h80, 32'h0);
    chk(pull, 16'hffff);
    ahb(1'b1, `GP_OUT_VALUE, 32'h0000_8000);
    cfg(15, mk(pin_pkg::FN_OUTPUT, PP, 3'h0, 16'h0));
    rd(`GP_CFG_TOP, mk(pin_pkg::FN_OUTPUT, PP, 3'h0, 16'h0));
    chk(oe_n, 16'hffff);
    @(posedge clk);
    rdone <= 1'b1;
    wt(3);
    chk({o_pin[15], oe_n[15]}, 2'b10);
    $display("test_reset done");
  endtask
  task test_io;
    @(posedge clk);
    ext_v[8] <= 1'b1;
    wt(4);
    rd(`GP_IN_LEVEL, 32'h0000_ff07);
    cfg(15, mk(pin_pkg::FN_OUTPUT, 5'h04, 3'h0, 16'h0)); // open drain, pull-down
    wt(3);
    chk({o_pin[15], oe_n[15], pull[15]}, 3'b010);
    ahb(1'b1, `GP_OUT_VALUE, 32'h0);
    wt(3);
    chk({o_pin[15], oe_n[15]}, 2'b00);
    ahb(1'b1, `GP_VDD_LEVEL, 32'h3);
    rd(`GP_VDD_LEVEL, 32'h3);
    chk(vdd, 2'h3);
    $display("test_io done");
  endtask
  task test_alarm;
    cfg(0, mk(pin_pkg::FN_LOS, PP, 3'h2, 16'h0));
    cfg(1, mk(pin_pkg::FN_LOS, PP, 3'h2, 16'h0));
    cfg(2, mk(pin_pkg::FN_LOS, PP | 5'h01, 3'h2, 16'h0));
    cfg(9, mk(pin_pkg::FN_LOCK, PP | 5'h02, 3'h0, 16'h0));
    cfg(10, mk(pin_pkg::FN_LOCK, PP, 3'h0, 16'h0));
    cfg(11, mk(pin_pkg::FN_HOLD, PP | 5'h02, 3'h1, 16'h0));
    cfg(12, mk(pin_pkg::FN_HOLD, PP, 3'h1, 16'h0));
    cfg(13, mk(pin_pkg::FN_ALERT, PP, 3'h0, 16'h0));
    cfg(14, mk(pin_pkg::FN_ALERT, PP | 5'h01, 3'h0, 16'h0));
    ahb(1'b1, `GP_ALERT_EN, 32'h0000_0201);
    rd(`GP_ALERT_EN, 32'h0000_0201);
    ahb(1'b1, `GP_STICKY, 32'h0000_ffff);
    rd(`GP_STICKY, 32'h0);
    chk(o_pin[14:9], 6'h20);
    @(posedge clk);
    los <= 8'h04;
    lkd[0] <= 1'b0;
    wt(4);
    chk(o_pin[2:0], 3'b011);
    chk(o_pin[14:9], 6'h13);
    rd(`GP_STICKY, 32'h1);
    rd(`GP_LIVE, 32'h0000_00fe);
    @(posedge clk);
    los <= 8'h00;
    lkd[0] <= 1'b1;
    hold[1] <= 1'b1;
    wt(4);
    chk(o_pin[2:0], 3'b100);
    chk(o_pin[14:9], 6'h1d);
    ahb(1'b1, `GP_STICKY, 32'h1);
    wt(3);
    chk(o_pin[14:9], 6'h1c);
    @(posedge clk);
    lkd[2] <= 1'b0;
    ahb(1'b1, `GP_STICKY, 32'h0200);
    wt(3);
    rd(`GP_STICKY, 32'h4);
    chk(o_pin[14:9], 6'h28);
    $display("test_alarm done");
  endtask
  task test_ctrl;
    cfg(4, mk(pin_pkg::FN_MAN_SEL, 5'h0, 3'h1, 16'h0));
    cfg(5, mk(pin_pkg::FN_OUT_DIS, 5'h0, 3'h0, 16'h00a5));
    cfg(6, mk(pin_pkg::FN_DISQ, 5'h0, 3'h5, 16'h0));
    cfg(7, mk(pin_pkg::FN_SE_CLK, 5'h0, 3'h0, 16'h0));
    wt(4);
    chk({ms_act, ms_hi, clk_dis}, 32'h0200_0000);
    @(posedge clk);
    ext_v[7:4] <= 4'hf;
    wt(2);
    chk(ms_hi, 8'h00);
    wt(2);
    chk({ms_hi, disq, clk_dis}, 32'h0220_00a5);
    chk(se_clk, 16'h0080);
    @(posedge clk);
    full[7] <= 1'b1;
    ext_v[6:4] <= 3'h0;
    wt(4);
    chk({ms_act, ms_hi, disq, clk_dis[7:0]}, 32'h0200_0000);
    chk(se_clk, 16'h0);
    $display("test_ctrl done");
  endtask
  // pin 3 steps up and pin 8 steps down on one channel; pin 8 starts high
  task test_step;
    int k, ni, nd;
    ni = 0;
    nd = 0;
    cfg(3, mk(pin_pkg::FN_INC, 5'h0, 3'h3, 16'h0));
    cfg(8, mk(pin_pkg::FN_DEC, 5'h0, 3'h3, 16'h0));
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      ext_v[3] <= (k % 8 < 4) && (k < 24);
      ext_v[8] <= (k % 6 < 3) && (k < 24);
      @(negedge clk);
      if (inc === 8'h08) ni++;
      if (dec === 8'h08) nd++;
    end
    chk(ni, 3);
    chk(nd, 3);
    $display("test_step done");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    {nrst, rdone, hsel, hwrite, htrans, haddr, hwdata} = 70'h0;
    {ext_v, full, los, hold} = 48'h0;
    lkd = 8'hff;
    ext_e = 16'h01f8;
    error_cnt = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    hsel <= 1'b1;
    test_reset;
    test_io;
    test_alarm;
    test_ctrl;
    test_step;
    stop_test;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule // test_multifunction_pin_control
